// ---- design/sbc_bank.sv ----
// secure bypass configuration register bank and bypass attribute logic
`timescale 1ns/10ps
`default_nettype none
`include "sbc_params.svh"

// ==========================================================
// overview
//
// the bank holds two words: the secure copy, which carries every
// bypass attribute control, and the non-secure copy, which here
// carries only the stall controls
//
// secure word layout
//   31:30  reserved, read zero
//   29:28  security override for secure bypassing requests
//   27:26  write allocate hint override
//   25:24  read allocate hint override
//   23:22  shareability override
//   21     match conflict fault enable
//   20     memory type override enable
//   19:16  memory attribute overlay
//   15:14  barrier shareability upgrade
//   13     force broadcast of maintenance
//   12     private tlb maintenance
//   11     reserved, read zero
//   10     unmatched stream fault enable
//   9      global stall enable
//   8      stall disable
//   7:1    reserved, read zero
//   0      client port bypass
//
// non-secure word layout
//   9      global stall enable for non-secure contexts
//   8      stall disable for non-secure contexts
//   others read zero and ignore writes
//
// register bus
//   a write lands at the edge that samples the strobe
//   read data stand in the cycle after the read strobe, else zero
//   unmapped addresses read zero and ignore writes
//   no wait states: the bank answers every access at once
//
// request path
//   one request descriptor is resolved per clock; the answer is
//   registered and stands for exactly one cycle after the request
//   overrides apply only to requests that skip the mapping table
//   because they matched nothing or matched several entries; a
//   request passed by the port bypass keeps its own attributes
//
// limitations
//   fields without a defined reset value start at zero here
//   the reserved override code 01 keeps the default attribute
//   optional fields left out read zero, but match conflict fault reads SMCF_FIXED and private tlb maintenance reads one without broadcast
//   a write setting stall disable also clears global stall in its word
//   secure hypervisor entries are not singled out by this bank
module sbc_bank #(
   parameter bit HAS_WALLOC   = 1'b1,
   parameter bit HAS_RALLOC   = 1'b1,
   parameter bit HAS_SHARE    = 1'b1,
   parameter bit SMCF_CONFIG  = 1'b1,
   parameter bit SMCF_FIXED   = 1'b0,
   parameter bit HAS_BSU      = 1'b1,
   parameter bit HAS_BTM      = 1'b1,
   parameter bit HAS_PTM      = 1'b1,
   parameter bit HAS_GSE      = 1'b1,
   parameter bit NS_STALL_SEC = 1'b1
) (
   input  wire logic            clk_sys,
   input  wire logic            nrst,
   input  wire logic [7:0]      reg_addr,
   input  wire logic [31:0]     reg_wdata,
   input  wire logic            reg_wr,
   input  wire logic            reg_rd,
   output logic [31:0]          reg_rdata,
   input  wire sbc_pkg::sbc_txn_t txn_in,
   output sbc_pkg::sbc_res_t    txn_out,
   output logic                 client_port_bypass,
   output logic                 global_stall_s,
   output logic                 global_stall_ns,
   output logic                 ctx_stall_ok_s,
   output logic                 ctx_stall_ok_ns,
   output logic                 tlb_bcast_required,
   output logic                 tlb_bcast_permitted
);

   // ==========================================================
   // helper functions

   // two-bit hint override: 10 gives v10, 11 gives its inverse
   // the reserved code 01 and code 00 both keep the default value
   function automatic logic sbc_hint(
      input logic [1:0] cfg,
      input logic       dflt,
      input logic       v10
   );
      logic r;
      r = dflt;
      if (cfg == 2'h2) begin
         r = v10;
      end else if (cfg == 2'h3) begin
         r = ~v10;
      end
      return r;
   endfunction

   // two-bit mask of a field whose support is optional
   function automatic logic [31:0] sbc_fld2(
      input bit have,
      input int lo
   );
      logic [31:0] m;
      m = 32'h0000_0000;
      if (have) begin
         m[lo +: 2] = 2'h3;
      end
      return m;
   endfunction

   // barrier domain order: none < inner < outer < full system
   // the codes already rise with the domain, so a compare suffices
   function automatic logic [1:0] sbc_max2(
      input logic [1:0] a,
      input logic [1:0] b
   );
      return (a > b) ? a : b;
   endfunction

   // ==========================================================
   // writable masks fixed by the build options

   // always present fields plus the optional ones
   // a bit outside this mask is never stored, so a read of it returns
   // zero unless the view forces it to one, and a write to it is lost; this one mask serves both the
   // read-as-zero and the write-ignored duty of an absent field
   // force broadcast is always writable, hence its constant term
   localparam logic [31:0] SMASK =
      `SBC_BASE_MASK
      | sbc_fld2(HAS_WALLOC, `SBC_BYPASS_WRITE_ALLOC_HINT_LO)
      | sbc_fld2(HAS_RALLOC, `SBC_BYPASS_READ_ALLOC_HINT_LO)
      | sbc_fld2(HAS_SHARE, `SBC_BYPASS_SHAREABILITY_LO)
      | sbc_fld2(HAS_BSU, `SBC_BSU_LO)
      | (32'(SMCF_CONFIG) << `SBC_SMCF_BIT)
      | (32'(HAS_BTM && HAS_PTM) << `SBC_PTM_BIT)
      | (32'h0000_2000)
      | (32'(HAS_GSE) << `SBC_GSE_BIT);

   // non-secure copy carries only the stall controls here
   // without global stall support only stall disable is stored
   // the security override bits stay reserved in this copy
   localparam logic [31:0] NMASK = HAS_GSE ? `SBC_NS_MASK
                                           : 32'h0000_0100;

   // ==========================================================
   // state

   // st holds every flop of the bank; next_st is its next value
   // the views are what software and the request path see
   sbc_pkg::sbc_state_t st;
   sbc_pkg::sbc_state_t next_st;

   logic [31:0] s_view;
   logic [31:0] n_view;
   logic        s_stall_disable;
   logic        n_stall_disable;
   logic        s_stall_off;

   // ==========================================================
   // register views as software reads them

   // fixed bits, read-as-one and forced-zero bits applied to stored words
   // the write path already clears global stall in the word on a
   // stall disable write; masking it on the view too keeps the read
   // and the stall outputs consistent whatever was stored
   always_comb begin
      s_view = st.scfg & SMASK;
      if (!SMCF_CONFIG) begin
         s_view[`SBC_SMCF_BIT] = SMCF_FIXED;
      end
      if (!HAS_BTM) begin
         s_view[`SBC_PTM_BIT] = 1'b1;
      end
      if (s_view[`SBC_STALL_DISABLE_BIT]) begin
         s_view[`SBC_GSE_BIT] = 1'b0;
      end
      n_view = st.bypass_security_override & NMASK;
      if (n_view[`SBC_STALL_DISABLE_BIT]) begin
         n_view[`SBC_GSE_BIT] = 1'b0;
      end
   end

   // stall controls of both security states
   // with the non-secure control also covering the secure side,
   // either stall disable switches off secure stalling
   always_comb begin
      s_stall_disable = s_view[`SBC_STALL_DISABLE_BIT];
      n_stall_disable = n_view[`SBC_STALL_DISABLE_BIT];
      s_stall_off = s_stall_disable | (NS_STALL_SEC & n_stall_disable);
   end

   // ==========================================================
   // next state

   // register writes, read data and request resolution all happen
   // in this one process; a read in the cycle after a write sees
   // the new word because the views are built from st, which has
   // taken the write at the edge between them
   always_comb begin
      logic [31:0]   wv;
      logic [1:0]    ns_cfg;
      logic [1:0]    wa_cfg;
      logic [1:0]    ra_cfg;
      logic [1:0]    sh_cfg;
      logic [1:0]    barrier_shareability_upgrade;
      logic          bypass_map;
      sbc_pkg::sbc_res_t r;
      wv = 32'h0000_0000;
      ns_cfg = s_view[`SBC_BYPASS_SECURITY_OVERRIDE_LO +: 2];
      wa_cfg = s_view[`SBC_BYPASS_WRITE_ALLOC_HINT_LO +: 2];
      ra_cfg = s_view[`SBC_BYPASS_READ_ALLOC_HINT_LO +: 2];
      sh_cfg = s_view[`SBC_BYPASS_SHAREABILITY_LO +: 2];
      barrier_shareability_upgrade = s_view[`SBC_BSU_LO +: 2];
      bypass_map = 1'b0;
      r = '0;
      next_st = st;

      // secure copy write: only implemented bits change
      if (reg_wr && reg_addr == `SBC_OFF_SCFG) begin
         wv = (st.scfg & ~SMASK) | (reg_wdata & SMASK);
         if (wv[`SBC_STALL_DISABLE_BIT]) begin
            wv[`SBC_GSE_BIT] = 1'b0;
         end
         next_st.scfg = wv;
      end

      // non-secure copy write: stall controls only
      if (reg_wr && reg_addr == `SBC_OFF_BYPASS_SECURITY_OVERRIDE) begin
         wv = reg_wdata & NMASK;
         if (wv[`SBC_STALL_DISABLE_BIT]) begin
            wv[`SBC_GSE_BIT] = 1'b0;
         end
         next_st.bypass_security_override = wv;
      end

      // read data for the cycle after the strobe, zero elsewhere
      next_st.rdata = 32'h0000_0000;
      if (reg_rd) begin
         if (reg_addr == `SBC_OFF_SCFG) begin
            next_st.rdata = s_view;
         end else if (reg_addr == `SBC_OFF_BYPASS_SECURITY_OVERRIDE) begin
            next_st.rdata = n_view;
         end
      end

      // defaults pass through unchanged
      r.valid = txn_in.valid;
      r.ns = txn_in.dflt_ns;
      r.walloc = txn_in.dflt_walloc;
      r.ralloc = txn_in.dflt_ralloc;
      r.share = txn_in.dflt_share;
      r.bypass_memory_attributes = txn_in.dflt_bypass_memory_attributes;
      r.bar_share = txn_in.bar_share;

      // decide whether stream mapping is bypassed or faulted
      // the port bypass wins over every fault: a request passed by it
      // never reaches the mapping stage, so neither fault can be raised
      // and no override applies
      if (s_view[`SBC_CPB_BIT]) begin
         r.bypass = 1'b1;
      end else if (txn_in.match_none) begin
         r.fault_unmatched = s_view[`SBC_USF_BIT];
         bypass_map = ~s_view[`SBC_USF_BIT];
      end else if (txn_in.match_multi) begin
         r.fault_conflict = s_view[`SBC_SMCF_BIT];
         bypass_map = ~s_view[`SBC_SMCF_BIT];
      end
      if (bypass_map) begin
         r.bypass = 1'b1;
      end

      // attribute overrides on requests that skip the mapping table
      // a mapped request keeps the attributes its context would give;
      // the descriptor's defaults stand in for them here
      if (bypass_map) begin
         if (txn_in.sec_state) begin
            r.ns = sbc_hint(ns_cfg, txn_in.dflt_ns, 1'b0);
         end
         if (txn_in.is_write) begin
            r.walloc = sbc_hint(wa_cfg, txn_in.dflt_walloc, 1'b1);
         end else begin
            r.ralloc = sbc_hint(ra_cfg, txn_in.dflt_ralloc, 1'b1);
         end
         if (sh_cfg != 2'h0) begin
            r.share = sh_cfg;
         end
         if (s_view[`SBC_BYPASS_MEMTYPE_OVERRIDE_EN_BIT]) begin
            r.bypass_memory_attributes = s_view[`SBC_MATTR_LO +: 4];
         end
         if (txn_in.is_barrier) begin
            r.bar_share = sbc_max2(txn_in.bar_share, barrier_shareability_upgrade);
         end
         if (txn_in.op != sbc_pkg::SBC_OP_NONE) begin
            r.bcast_is = s_view[`SBC_FB_BIT];
         end
      end
      next_st.res = r;
   end

   // ==========================================================
   // state register

   // asynchronous reset loads constants only; the bypass bit comes up
   // set so that clients are passed before software configures them
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         // stall disable and client bypass take their reset values
         next_st_dummy_guard: begin
            st.scfg <= `SBC_RST_SCFG;
            st.bypass_security_override <= `SBC_RST_BYPASS_SECURITY_OVERRIDE;
            st.rdata <= 32'h0000_0000;
            st.res <= '0;
         end
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // outputs

   // register read data and resolved request
   assign reg_rdata = st.rdata;
   assign txn_out = st.res;

   // bypass and stall controls driven from the stored words
   // they are combinational from flops only, so they change in the
   // cycle after the write that alters them and never follow the bus
   assign client_port_bypass = s_view[`SBC_CPB_BIT];
   assign global_stall_s = s_view[`SBC_GSE_BIT] & ~s_stall_off;
   assign global_stall_ns = n_view[`SBC_GSE_BIT];
   assign ctx_stall_ok_s = ~s_stall_off;
   assign ctx_stall_ok_ns = ~n_stall_disable;

   // broadcast maintenance participation; the private bit is a hint only
   // a build without broadcast support reads the private bit as one,
   // so tlb_bcast_required drops to zero there
   assign tlb_bcast_required = HAS_BTM & ~s_view[`SBC_PTM_BIT];
   assign tlb_bcast_permitted = HAS_BTM;

endmodule
`default_nettype wire

// ---- design/sbc_params.svh ----
// offsets, field positions, reset values of the bypass configuration bank
`ifndef SBC_PARAMS_SVH
`define SBC_PARAMS_SVH
// ==========================================================
// register offsets (byte addresses, one word each)
`define SBC_OFF_SCFG   8'h00
`define SBC_OFF_BYPASS_SECURITY_OVERRIDE  8'h04
// ==========================================================
// field positions
`define SBC_BYPASS_SECURITY_OVERRIDE_LO   28
`define SBC_BYPASS_WRITE_ALLOC_HINT_LO   26
`define SBC_BYPASS_READ_ALLOC_HINT_LO   24
`define SBC_BYPASS_SHAREABILITY_LO   22
`define SBC_SMCF_BIT   21
`define SBC_BYPASS_MEMTYPE_OVERRIDE_EN_BIT  20
`define SBC_MATTR_LO   16
`define SBC_BSU_LO     14
`define SBC_FB_BIT     13
`define SBC_PTM_BIT    12
`define SBC_USF_BIT    10
`define SBC_GSE_BIT    9
`define SBC_STALL_DISABLE_BIT 8
`define SBC_CPB_BIT    0
// ==========================================================
// reset values and fixed read masks
`define SBC_RST_SCFG   32'h0000_0001
`define SBC_RST_BYPASS_SECURITY_OVERRIDE  32'h0000_0000
`define SBC_BASE_MASK  32'h301f_0501
`define SBC_NS_MASK    32'h0000_0300
`endif

// ---- design/sbc_pkg.sv ----
// types shared by the bypass configuration bank
package sbc_pkg;
   // maintenance operation kind carried by a client request
   typedef enum logic [1:0] {
      SBC_OP_NONE = 2'h0,
      SBC_OP_TLB  = 2'h1,
      SBC_OP_BP   = 2'h2,
      SBC_OP_IC   = 2'h3
   } sbc_op_t;

   // one client request as seen at the stream mapping stage
   typedef struct packed {
      logic       valid;
      logic       sec_state;
      logic       is_write;
      logic       match_none;
      logic       match_multi;
      logic       is_barrier;
      sbc_op_t    op;
      logic       dflt_ns;
      logic       dflt_walloc;
      logic       dflt_ralloc;
      logic [1:0] dflt_share;
      logic [3:0] dflt_bypass_memory_attributes;
      logic [1:0] bar_share;
   } sbc_txn_t;

   // resolved handling of that request
   typedef struct packed {
      logic       valid;
      logic       bypass;
      logic       fault_unmatched;
      logic       fault_conflict;
      logic       ns;
      logic       walloc;
      logic       ralloc;
      logic [1:0] share;
      logic [3:0] bypass_memory_attributes;
      logic [1:0] bar_share;
      logic       bcast_is;
   } sbc_res_t;

   // whole state of the bank
   typedef struct packed {
      logic [31:0] scfg;
      logic [31:0] bypass_security_override;
      logic [31:0] rdata;
      sbc_res_t    res;
   } sbc_state_t;
endpackage

// ---- design/sbc_fix_note.sv ----
// holds no code: every part of the bank lives in the other three design files

// ---- verification/sbc_bank_properties.sv ----
// concurrent checks on the ports of the bypass configuration bank
`timescale 1ns/10ps
`default_nettype none
`include "sbc_params.svh"

// ==========================================================
// checker module
module sbc_bank_props (
   input wire logic              clk_sys,
   input wire logic              nrst,
   input wire logic [7:0]        reg_addr,
   input wire logic [31:0]       reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [31:0]       reg_rdata,
   input wire sbc_pkg::sbc_txn_t txn_in,
   input wire sbc_pkg::sbc_res_t txn_out,
   input wire logic              client_port_bypass,
   input wire logic              global_stall_s,
   input wire logic              global_stall_ns,
   input wire logic              ctx_stall_ok_s,
   input wire logic              ctx_stall_ok_ns
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   // read data only in the cycle after a read strobe
   AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside read answer");
   AST_RSVD_ZERO: assert property ($past(reg_rd) |->
      reg_rdata[31:30] == 2'h0 && !reg_rdata[11] && reg_rdata[7:1] == 7'h0)
      else $error("reserved bits read nonzero");
   AST_NS_RSVD: assert property (
      $past(reg_rd) && $past(reg_addr) == `SBC_OFF_BYPASS_SECURITY_OVERRIDE
      |-> (reg_rdata & 32'hffff_fcff) == 32'h0)
      else $error("non-secure word shows unimplemented bits");
   AST_GSE_RAZ: assert property (
      $past(reg_rd) && reg_rdata[8] |-> !reg_rdata[9])
      else $error("global stall reads one under stall disable");
   // stall disable kills both stall outputs of its word
   AST_STALL_DISABLE_S: assert property (
      reg_wr && reg_addr == `SBC_OFF_SCFG && reg_wdata[8]
      |=> !global_stall_s && !ctx_stall_ok_s)
      else $error("secure stalling left enabled");
   AST_STALL_DISABLE_NS: assert property (
      reg_wr && reg_addr == `SBC_OFF_BYPASS_SECURITY_OVERRIDE && reg_wdata[8]
      |=> !global_stall_ns && !ctx_stall_ok_ns)
      else $error("non-secure stalling left enabled");
   AST_BYP_LEVEL: assert property (
      reg_wr && reg_addr == `SBC_OFF_SCFG
      |=> client_port_bypass == $past(reg_wdata[0]))
      else $error("port bypass level not from written bit");
   // request resolution one cycle after the request
   AST_PORT_BYP: assert property (
      client_port_bypass && txn_in.valid |=> txn_out.bypass
      && !txn_out.fault_unmatched && !txn_out.fault_conflict)
      else $error("port bypass request faulted or mapped");
   AST_UNMATCHED: assert property (
      !client_port_bypass && txn_in.valid && txn_in.match_none
      |=> txn_out.valid && txn_out.fault_unmatched != txn_out.bypass)
      else $error("unmatched request both bypassed and faulted");
   AST_CONFLICT: assert property (
      !client_port_bypass && txn_in.valid && !txn_in.match_none
      && txn_in.match_multi |=> !txn_out.fault_unmatched
      && txn_out.fault_conflict != txn_out.bypass)
      else $error("conflicting request resolved wrongly");
endmodule

bind sbc_bank sbc_bank_props u_sbc_bank_props (
   .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .txn_in(txn_in), .txn_out(txn_out),
   .client_port_bypass(client_port_bypass),
   .global_stall_s(global_stall_s), .global_stall_ns(global_stall_ns),
   .ctx_stall_ok_s(ctx_stall_ok_s), .ctx_stall_ok_ns(ctx_stall_ok_ns));
`default_nettype wire

// ---- verification/sbc_client.sv ----
// client bus master model issuing requests into the bank
`timescale 1ns/10ps
`default_nettype none

module sbc_client (
   input  wire logic             clk_sys,
   output var sbc_pkg::sbc_txn_t txn
);
   // idle from time zero
   initial txn = '0;

   // secure hypervisor entries are kept by direct register maintenance,
   // so the model issues no broadcast meant for them
   // one request for one cycle, then valid low with the payload inverted
   task automatic send(input sbc_pkg::sbc_txn_t t);
      @(posedge clk_sys);
      txn <= t;
      @(posedge clk_sys);
      txn <= {1'b0, ~t[17:0]};
   endtask
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench for the bypass configuration bank
`timescale 1ns/10ps
`default_nettype none
`include "sbc_params.svh"

module testbench;
   logic              clk_sys = 1'b0;
   logic              nrst = 1'b0;
   logic [7:0]        reg_addr = 8'h00;
   logic [31:0]       reg_wdata = 32'h0;
   logic              reg_wr = 1'b0;
   logic              reg_rd = 1'b0;
   logic [31:0]       reg_rdata;
   sbc_pkg::sbc_txn_t txn_in;
   sbc_pkg::sbc_res_t txn_out;
   logic              cpb, gss, gsn, cos, con, tbr, tbp;
   int                errors = 0;
   int                cmp_count = 0;
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
   $display("ERROR at %0t: got %h expected %h", $time, a, e); end end

   // ==========================================================
   // clock, design and client model
   always #10 clk_sys = ~clk_sys;
   sbc_bank u_sbc_bank (.clk_sys(clk_sys), .nrst(nrst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .txn_in(txn_in),
      .txn_out(txn_out), .client_port_bypass(cpb), .global_stall_s(gss),
      .global_stall_ns(gsn), .ctx_stall_ok_s(cos), .ctx_stall_ok_ns(con),
      .tlb_bcast_required(tbr), .tlb_bcast_permitted(tbp));
   sbc_client u_sbc_client (.clk_sys(clk_sys), .txn(txn_in));

   // ==========================================================
   // bus and request helpers
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
      #1;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
   endtask
   // f: secure, write, unmatched, multi match, default non-secure
   function automatic sbc_pkg::sbc_txn_t mk(input logic [4:0] f,
                                           input sbc_pkg::sbc_op_t op);
      return '{1'b1, f[4], f[3], f[2], f[1], 1'b1, op, f[0], 1'b0, 1'b1,
               2'h0, 4'h5, 2'h1};
   endfunction
   task automatic tx(input logic [4:0] f, input sbc_pkg::sbc_op_t op,
                     input logic [15:0] e);
      u_sbc_client.send(mk(f, op));
      #1;
      `CHK(txn_out, e)
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset;
      rd_chk(`SBC_OFF_SCFG, 32'h0000_0001);
      rd_chk(`SBC_OFF_BYPASS_SECURITY_OVERRIDE, 32'h0000_0000);
      `CHK({cpb, gss, gsn, cos, con, tbr, tbp}, 7'h4f)
      tx(5'b11100, sbc_pkg::SBC_OP_TLB, 16'hc22a);
      $display("reset values done");
   endtask
   task automatic t_regs;
      wr(`SBC_OFF_SCFG, 32'hffff_ffff);
      rd_chk(`SBC_OFF_SCFG, 32'h3fff_f501);
      `CHK({gss, cos}, 2'h0)
      wr(`SBC_OFF_SCFG, 32'h0000_0200);
      `CHK({cpb, gss, cos, tbr}, 4'h7)
      wr(`SBC_OFF_SCFG, 32'h0000_1000);
      `CHK(tbr, 1'b0)
      wr(8'h08, 32'hffff_ffff);
      rd_chk(8'h08, 32'h0);
      wr(`SBC_OFF_BYPASS_SECURITY_OVERRIDE, 32'hffff_ffff);
      rd_chk(`SBC_OFF_BYPASS_SECURITY_OVERRIDE, 32'h0000_0100);
      `CHK({gsn, con, cos}, 3'h0)
      wr(`SBC_OFF_BYPASS_SECURITY_OVERRIDE, 32'h0000_0200);
      `CHK({gsn, con, cos}, 3'h7)
      $display("register access done");
   endtask
   task automatic t_txn;
      wr(`SBC_OFF_SCFG, 32'h3b7a_a000);
      tx(5'b11100, sbc_pkg::SBC_OP_TLB, 16'hced5);
      tx(5'b11100, sbc_pkg::SBC_OP_BP, 16'hced5);
      tx(5'b11100, sbc_pkg::SBC_OP_IC, 16'hced5);
      tx(5'b11100, sbc_pkg::SBC_OP_NONE, 16'hced4);
      tx(5'b10100, sbc_pkg::SBC_OP_NONE, 16'hc8d4);
      tx(5'b11010, sbc_pkg::SBC_OP_NONE, 16'h922a);
      tx(5'b11000, sbc_pkg::SBC_OP_NONE, 16'h822a);
      tx(5'b01100, sbc_pkg::SBC_OP_NONE, 16'hc6d4);
      wr(`SBC_OFF_SCFG, 32'h2b7a_a000);
      tx(5'b11101, sbc_pkg::SBC_OP_NONE, 16'hc6d4);
      wr(`SBC_OFF_SCFG, 32'h3b4a_a000);
      tx(5'b11010, sbc_pkg::SBC_OP_NONE, 16'hceac);
      wr(`SBC_OFF_SCFG, 32'h3b7a_a400);
      tx(5'b11100, sbc_pkg::SBC_OP_TLB, 16'ha22a);
      $display("request resolution done");
   endtask

   // ==========================================================
   // verdict, main sequence and watchdog
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      t_reset;
      t_regs;
      t_txn;
      summarize;
   end
   initial begin
      #200us;
      errors++;
      summarize;
   end
endmodule
`default_nettype wire
